// ==== gsm_pin_mux.sv ====
// Digital pin function mux with scan port takeover and analog ports
`timescale 1ns/1ns
`default_nettype none
module gsm_pin_mux (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Configuration from the device's control registers
  input  wire logic [23:0] cfg_dir_i,
  input  wire logic [23:0] cfg_mon_en_i,
  input  wire logic [23:0] cfg_gain_en_i,
  input  wire logic [1:0]  cfg_mon_ptr_i,
  input  wire logic [23:0] cfg_out_val_i,
  input  wire logic [15:0] cfg_ana_dir_i,
  input  wire logic [15:0] cfg_ana_out_i,
  // Internal monitor sources
  input  wire logic [23:0] mon_gain_i,
  input  wire logic [23:0] mon_cal_i,
  input  wire logic [23:0] mon_state_i,
  input  wire logic [23:0] mon_rx_i,
  // Digital pins
  input  wire logic [23:0] gpio_in_i,
  output logic      [23:0] gpio_out_o,
  output logic      [23:0] gpio_oe_o,
  input  wire logic        test_en_i,
  // Analog control ports
  input  wire logic [15:0] analog_control_ports_in_i,
  output logic      [15:0] analog_control_ports_out_o,
  output logic      [15:0] analog_control_ports_oe_o,
  output logic      [15:0] analog_control_ports_rd_o,
  // Internal side
  output logic      [23:0] gpio_rd_o,
  output logic      [7:0]  rx_gain_o,
  output logic             rx_gain_upd_o,
  output logic      [1:0]  scan_mode_o,
  output logic             scan_active_o,
  output logic             tap_trst_o,
  output logic             tap_tdi_o,
  output logic             tap_tms_o,
  output logic             tap_tck_o,
  input  wire logic        tap_tdo_i,
  input  wire logic        tap_tdo_en_i
);

  ////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [23:0] pin_s;
  logic        test_en_s;
  logic [15:0] ana_s;

  gsm_sync #(.W(41)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({test_en_i, analog_control_ports_in_i, gpio_in_i}),
    .sync_o    ({test_en_s, ana_s, pin_s})
  );

  ////////////////////////////////////////////////////////////////////
  // Scan mode decode

  function automatic gsm_pkg::gsm_scan_t scan_decode(input logic en, input logic [2:0] code);
    if (!en)
      scan_decode = gsm_pkg::SCAN_OFF;
    else if (code == gsm_pkg::CODE_LVDS)
      scan_decode = gsm_pkg::SCAN_LVDS;
    else if (code == gsm_pkg::CODE_CMOS)
      scan_decode = gsm_pkg::SCAN_CMOS;
    else
      scan_decode = gsm_pkg::SCAN_OFF;
  endfunction

  // Tester holds enable and code steady; decode follows the synced level
  gsm_pkg::gsm_scan_t scan_nxt;
  gsm_pkg::gsm_scan_t scan_r;
  wire  [2:0] mode_code = pin_s[gsm_pkg::MODE_LSB +: gsm_pkg::MODE_W];

  assign scan_nxt = scan_decode(test_en_s, mode_code);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      scan_r <= gsm_pkg::SCAN_OFF;
    else
      scan_r <= scan_nxt;
  end

  wire scan_on = (scan_r != gsm_pkg::SCAN_OFF);

  ////////////////////////////////////////////////////////////////////
  // Monitor source select

  logic [23:0] mon_sel;

  always_comb begin
    unique case (gsm_pkg::gsm_src_t'(cfg_mon_ptr_i))
      gsm_pkg::SRC_GAIN:  mon_sel = mon_gain_i;
      gsm_pkg::SRC_CAL:   mon_sel = mon_cal_i;
      gsm_pkg::SRC_STATE: mon_sel = mon_state_i;
      gsm_pkg::SRC_RX:    mon_sel = mon_rx_i;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Per-pin normal function

  logic [23:0] norm_out;
  logic [23:0] norm_oe;

  genvar gi;
  generate
    for (gi = 0; gi < gsm_pkg::NUM_PINS; gi++) begin : g_pin
      assign norm_oe[gi]  = cfg_dir_i[gi];
      assign norm_out[gi] = cfg_mon_en_i[gi] ? mon_sel[gi] : cfg_out_val_i[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Scan takeover of pins 3..7; only the data output is driven

  logic [23:0] scan_mask;
  logic [23:0] pin_out_nxt;
  logic [23:0] pin_oe_nxt;
  logic [23:0] pin_out_r;
  logic [23:0] pin_oe_r;

  always_comb begin
    scan_mask = '0;
    scan_mask[gsm_pkg::PIN_TRST] = 1'b1;
    scan_mask[gsm_pkg::PIN_TDO]  = 1'b1;
    scan_mask[gsm_pkg::PIN_TDI]  = 1'b1;
    scan_mask[gsm_pkg::PIN_TMS]  = 1'b1;
    scan_mask[gsm_pkg::PIN_TCK]  = 1'b1;
    pin_out_nxt = norm_out;
    pin_oe_nxt  = norm_oe;
    if (scan_on) begin
      pin_oe_nxt  = norm_oe & ~scan_mask;
      pin_out_nxt = norm_out & ~scan_mask;
      pin_out_nxt[gsm_pkg::PIN_TDO] = tap_tdo_i;
      pin_oe_nxt[gsm_pkg::PIN_TDO]  = tap_tdo_en_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_out_r <= '0;
      pin_oe_r  <= gsm_pkg::DIR_RESET;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  assign gpio_out_o = pin_out_r;
  assign gpio_oe_o  = pin_oe_r;
  assign gpio_rd_o  = pin_s;

  // Scan port inputs, idle while scan is off; registered so the gated clock cannot glitch
  logic [3:0] tap_pins;
  logic [3:0] tap_nxt;
  logic [3:0] tap_r;

  assign tap_pins = {pin_s[gsm_pkg::PIN_TRST], pin_s[gsm_pkg::PIN_TDI],
                     pin_s[gsm_pkg::PIN_TMS], pin_s[gsm_pkg::PIN_TCK]};
  assign tap_nxt  = scan_on ? tap_pins : 4'h0;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      tap_r <= '0;
    else
      tap_r <= tap_nxt;
  end

  assign tap_trst_o    = tap_r[3];
  assign tap_tdi_o     = tap_r[2];
  assign tap_tms_o     = tap_r[1];
  assign tap_tck_o     = tap_r[0];
  assign scan_active_o = scan_on;
  assign scan_mode_o   = scan_r;

  ////////////////////////////////////////////////////////////////////
  // Real-time gain from input pins 8..15

  logic [7:0] gain_nxt;
  logic [7:0] gain_r;
  logic       gain_upd_r;
  wire  [7:0] gain_en = cfg_gain_en_i[gsm_pkg::GAIN_PIN_LSB +: gsm_pkg::GAIN_W];
  wire  [7:0] gain_in = pin_s[gsm_pkg::GAIN_PIN_LSB +: gsm_pkg::GAIN_W];
  wire  [7:0] gain_dir = cfg_dir_i[gsm_pkg::GAIN_PIN_LSB +: gsm_pkg::GAIN_W];

  // Bits not enabled as gain inputs keep their last value
  assign gain_nxt = (gain_in & gain_en & ~gain_dir) | (gain_r & ~(gain_en & ~gain_dir));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      gain_r     <= '0;
      gain_upd_r <= 1'b0;
    end else begin
      gain_r     <= gain_nxt;
      gain_upd_r <= (gain_nxt != gain_r);
    end
  end

  assign rx_gain_o     = gain_r;
  assign rx_gain_upd_o = gain_upd_r;

  ////////////////////////////////////////////////////////////////////
  // Analog control ports

  logic [15:0] ana_out_r;
  logic [15:0] ana_oe_r;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ana_out_r <= '0;
      ana_oe_r  <= gsm_pkg::ANA_DIR_RESET;
    end else begin
      ana_out_r <= cfg_ana_out_i & cfg_ana_dir_i;
      ana_oe_r  <= cfg_ana_dir_i;
    end
  end

  assign analog_control_ports_out_o = ana_out_r;
  assign analog_control_ports_oe_o  = ana_oe_r;
  assign analog_control_ports_rd_o  = ana_s;

endmodule // gsm_pin_mux
`default_nettype wire

// ==== gsm_pkg.sv ====
// Constants and types for the general-purpose pin and scan mux
package gsm_pkg;
  localparam int unsigned NUM_PINS      = 24;
  localparam int unsigned NUM_ANA       = 16;
  localparam int unsigned PTR_W         = 2;
  localparam int unsigned GAIN_W        = 8;
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_W        = 3;
  localparam int unsigned PIN_TRST      = 3;
  localparam int unsigned PIN_TDO       = 4;
  localparam int unsigned PIN_TDI       = 5;
  localparam int unsigned PIN_TMS       = 6;
  localparam int unsigned PIN_TCK       = 7;
  localparam int unsigned GAIN_PIN_LSB  = 8;
  localparam logic [2:0]  CODE_LVDS     = 3'h0;
  localparam logic [2:0]  CODE_CMOS     = 3'h3;
  localparam logic [23:0] DIR_RESET     = 24'h000000;
  localparam logic [23:0] MON_EN_RESET  = 24'h000000;
  localparam logic [23:0] GAIN_EN_RESET = 24'h000000;
  localparam logic [15:0] ANA_DIR_RESET = 16'h0000;
  localparam logic [1:0]  PTR_RESET     = 2'h0;

  typedef enum logic [1:0] {
    SRC_GAIN,
    SRC_CAL,
    SRC_STATE,
    SRC_RX
  } gsm_src_t;

  typedef enum logic [1:0] {
    SCAN_OFF,
    SCAN_LVDS,
    SCAN_CMOS
  } gsm_scan_t;
endpackage

// ==== gsm_sync.sv ====
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ns
`default_nettype none
module gsm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // gsm_sync
`default_nettype wire

// ==== gsm_pin_mux_assertions.sv ====
// Checker for scan decode, pin takeover and gain update of the pin mux
`timescale 1ns/1ns
`default_nettype none
module gsm_pin_mux_assertions (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        test_en_i,
  input wire logic [23:0] gpio_in_i,
  input wire logic [23:0] cfg_dir_i,
  input wire logic [23:0] gpio_out_o,
  input wire logic [23:0] gpio_oe_o,
  input wire logic [7:0]  rx_gain_o,
  input wire logic        rx_gain_upd_o,
  input wire logic [1:0]  scan_mode_o,
  input wire logic        scan_active_o,
  input wire logic        tap_tck_o,
  input wire logic        tap_tdo_i,
  input wire logic        tap_tdo_en_i
);
  logic [2:0] rc_r;
  logic [2:0] st_r;
  logic [3:0] md_r;
  logic       act_r;
  wire  [3:0] md = {test_en_i, gpio_in_i[2:0]};
  wire        ok = rc_r == 3'h7;
  // Mode pins steady long enough to pass the synchroniser, and unchanged now
  wire        q  = ok && st_r > 3'h4 && md == md_r;
  // Scan on now and at the previous edge
  wire        on = scan_active_o && act_r;
  always_ff @(posedge ref_clk_i) begin
    rc_r <= reset_i ? 3'h0 : rc_r + {2'h0, !ok};
    act_r <= reset_i ? 1'h0 : scan_active_o;
    md_r <= md;
    st_r <= (reset_i || md != md_r) ? 3'h0 : st_r + {2'h0, st_r != 3'h7};
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  AST_SCAN_OFF: assert property (q && !test_en_i |-> scan_mode_o == 2'h0 && !scan_active_o)
    else $error("scan active with test enable low");
  AST_SCAN_LVDS: assert property (q && md == {1'h1, gsm_pkg::CODE_LVDS} |-> scan_mode_o == 2'h1)
    else $error("code 000 did not give differential scan");
  AST_SCAN_CMOS: assert property (q && md == {1'h1, gsm_pkg::CODE_CMOS} |-> scan_mode_o == 2'h2)
    else $error("cmos code did not give single-ended scan");
  AST_SCAN_OTHER: assert property (q && test_en_i && gpio_in_i[2:0] != gsm_pkg::CODE_LVDS
    && gpio_in_i[2:0] != gsm_pkg::CODE_CMOS |-> !scan_active_o) else $error("unknown code gave scan");
  AST_TAKEOVER: assert property (on |-> (gpio_oe_o[7:3] & 5'h1d) == 5'h0)
    else $error("scan input pin still driven");
  AST_TDO: assert property (on |-> gpio_oe_o[4] == $past(tap_tdo_en_i) && gpio_out_o[4] == $past(tap_tdo_i))
    else $error("test data output not on pin 4");
  AST_TCK_GATE: assert property (!scan_active_o && !$past(scan_active_o) |-> !tap_tck_o)
    else $error("test clock passed while scan off");
  AST_DIR: assert property (ok |-> gpio_oe_o[2:0] == $past(cfg_dir_i[2:0]))
    else $error("pin enable does not follow direction");
  AST_GAIN_UPD: assert property (ok && rx_gain_o != $past(rx_gain_o) |-> ##[0:1] rx_gain_upd_o)
    else $error("gain change without update pulse");
  COV_LVDS: cover property (scan_mode_o == 2'h1);
  COV_CMOS: cover property (scan_mode_o == 2'h2);
  COV_GAIN: cover property (rx_gain_upd_o);
endmodule // gsm_pin_mux_assertions
bind gsm_pin_mux gsm_pin_mux_assertions i_gsm_pin_mux_assertions (
  .ref_clk_i, .reset_i, .test_en_i, .gpio_in_i, .cfg_dir_i, .gpio_out_o, .gpio_oe_o,
  .rx_gain_o, .rx_gain_upd_o, .scan_mode_o, .scan_active_o, .tap_tck_o, .tap_tdo_i,
  .tap_tdo_en_i
);
`default_nettype wire

// ==== gsm_far_model.sv ====
// Far side of the pins: processor and scan tester driving undriven pins
`timescale 1ns/1ns
`default_nettype none
module gsm_far_model #(
  parameter int unsigned W = 24
) (
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] drive_i,
  output logic      [W-1:0] pin_o
);
  // Far side always drives, so a released pin never keeps a stale level
  assign pin_o = (oe_i & out_i) | (~oe_i & drive_i);
endmodule // gsm_far_model
`default_nettype wire

// ==== gsm_pin_mux_tb.sv ====
// Self-checking bench for the pin mux
`timescale 1ns/1ns
`default_nettype none
module gsm_pin_mux_tb;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        ten = 1'h0;
  logic        tdo = 1'h0;
  logic        tdo_en = 1'h0;
  logic [1:0]  ptr = 2'h0;
  logic [1:0]  m;
  logic [7:0]  g_exp = 8'h0, g_old = 8'h0;
  logic [15:0] adir = 16'h0, aout = 16'h0, adrv = 16'h0;
  logic [23:0] dir = 24'h0, men = 24'h0, gen = 24'h0, oval = 24'h0, drv = 24'h0;
  logic [23:0] mon [4] = '{24'h0, 24'h0, 24'h0, 24'h0};
  wire  [23:0] pin, gout, goe, grd;
  wire  [15:0] ain, ao, aoe, ard;
  wire  [7:0]  gain;
  wire  [1:0]  smode;
  wire         upd, sact, trst, tdi, tms, tck;
  int          failures = 0;
  int          n_compared = 0;
  gsm_pin_mux i_gsm_pin_mux (
    .ref_clk_i(clk), .reset_i(rst), .cfg_dir_i(dir), .cfg_mon_en_i(men),
    .cfg_gain_en_i(gen), .cfg_mon_ptr_i(ptr), .cfg_out_val_i(oval), .cfg_ana_dir_i(adir),
    .cfg_ana_out_i(aout), .mon_gain_i(mon[0]), .mon_cal_i(mon[1]), .mon_state_i(mon[2]),
    .mon_rx_i(mon[3]), .gpio_in_i(pin), .gpio_out_o(gout), .gpio_oe_o(goe), .test_en_i(ten),
    .analog_control_ports_in_i(ain), .analog_control_ports_out_o(ao),
    .analog_control_ports_oe_o(aoe), .analog_control_ports_rd_o(ard), .gpio_rd_o(grd),
    .rx_gain_o(gain), .rx_gain_upd_o(upd), .scan_mode_o(smode), .scan_active_o(sact),
    .tap_trst_o(trst), .tap_tdi_o(tdi), .tap_tms_o(tms), .tap_tck_o(tck),
    .tap_tdo_i(tdo), .tap_tdo_en_i(tdo_en));
  gsm_far_model i_gsm_far_model (.out_i(gout), .oe_i(goe), .drive_i(drv), .pin_o(pin));
  gsm_far_model #(.W(16)) i_gsm_far_model_ana (.out_i(ao), .oe_i(aoe), .drive_i(adrv),
    .pin_o(ain));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] exp_mode(input logic en, input logic [2:0] code);
    return !en ? 2'h0 : code == gsm_pkg::CODE_LVDS ? 2'h1 :
           code == gsm_pkg::CODE_CMOS ? 2'h2 : 2'h0;
  endfunction
  ////////////////////////////////////////
  initial begin
    void'($urandom(71));
    // Reset clears both synchroniser stages at once
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk("oe_reset", goe, 24'h0);
    for (int i = 0; i < 20; i++) begin
      dir = 24'($urandom);
      men = 24'($urandom);
      oval = 24'($urandom);
      ptr = 2'(i);
      for (int k = 0; k < 4; k++) mon[k] = 24'($urandom);
      repeat (2) @(negedge clk);
      chk("gpio_oe", goe, dir);
      chk("gpio_out", gout & dir, (men & mon[ptr] | ~men & oval) & dir);
    end
    $display("test monitor done");
    dir = 24'h0;
    // Pins settle as inputs before gain bits are enabled, so no stale word lands
    repeat (4) @(negedge clk);
    gen = 24'h00ff00;
    for (int i = 0; i < 9; i++) begin
      if (i == 8) gen = 24'h00fe00;
      drv = (i == 8) ? drv ^ 24'h000100 : 24'($urandom) & 24'h00fff8;
      g_old = g_exp;
      g_exp = (i == 8) ? drv[15:8] ^ 8'h01 : drv[15:8];
      repeat (3) @(negedge clk);
      chk("rx_gain_upd", upd, g_exp != g_old);
      repeat (3) @(negedge clk);
      chk("rx_gain", gain, g_exp);
      chk("rx_gain_upd_idle", upd, 1'h0);
      chk("gpio_rd", grd, pin);
    end
    $display("test gain done");
    dir = 24'hfffff8;
    men = 24'h0;
    for (int c = 0; c < 9; c++) begin
      ten = c < 8;
      drv = {24'($urandom) & 24'hfffff8} | 24'(c[2:0]);
      tdo = 1'($urandom);
      tdo_en = 1'($urandom);
      repeat (8) @(negedge clk);
      m = exp_mode(ten, drv[2:0]);
      chk("scan_mode", smode, m);
      chk("scan_active", sact, m != 2'h0);
      if (m != 2'h0) begin
        chk("scan_oe", goe[7:3], {3'h0, tdo_en, 1'h0});
        chk("tap_in", {trst, tdi, tms, tck}, {drv[3], drv[5], drv[6], drv[7]});
        chk("tap_tdo", gout[4], tdo);
      end else begin
        chk("normal_oe", goe[7:3], 5'h1f);
        chk("tap_off", {trst, tdi, tms, tck}, 4'h0);
      end
    end
    $display("test scan done");
    for (int i = 0; i < 4; i++) begin
      adir = 16'($urandom);
      aout = 16'($urandom);
      adrv = 16'($urandom);
      repeat (4) @(negedge clk);
      chk("ana_oe", aoe, adir);
      chk("ana_out", ao & adir, aout & adir);
      chk("ana_rd", ard, ain);
    end
    $display("test analog done");
    report_and_stop();
  end
endmodule // gsm_pin_mux_tb
`default_nettype wire
